/* File: src/srs_fifo.sv */
// Purpose: Synchronous FIFO with valid and ready on both sides
// Assumes: Single clock, synchronous active-high reset, clock enable
// Notes:   Full and empty come from a pointer pair with one wrap bit
`timescale 1ns/1ps
module srs_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 16
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             ce,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);

  localparam int unsigned PTR_W = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PTR_W:0]   wr_ptr_q;
  logic [PTR_W:0]   wr_ptr_d;
  logic [PTR_W:0]   rd_ptr_q;
  logic [PTR_W:0]   rd_ptr_d;
  logic             push;
  logic             pop;

  // Full when the pointers differ only in the wrap bit
  assign in_ready  = !((wr_ptr_q[PTR_W] != rd_ptr_q[PTR_W]) &&
                       (wr_ptr_q[PTR_W-1:0] == rd_ptr_q[PTR_W-1:0]));
  assign out_valid = (wr_ptr_q != rd_ptr_q);
  assign out_data  = mem_q[rd_ptr_q[PTR_W-1:0]];
  assign push      = ce && in_valid && in_ready;
  assign pop       = ce && out_valid && out_ready;

  // Pointer advance
  always_comb begin
    wr_ptr_d = push ? wr_ptr_q + 1'b1 : wr_ptr_q;
    rd_ptr_d = pop ? rd_ptr_q + 1'b1 : rd_ptr_q;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
    end else begin
      wr_ptr_q <= wr_ptr_d;
      rd_ptr_q <= rd_ptr_d;
    end
  end

  // Storage needs no reset; empty flag hides stale words
  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_ptr_q[PTR_W-1:0]] <= in_data;
    end
  end

endmodule

/* File: src/srs_pkg.sv */
// Purpose: Shared constants for the serial register access slave and its FIFO
// Assumes: Link signals are sampled by the 10 MHz core clock
// Notes:   FIFO register address is a plain default, change to suit the map
package srs_pkg;

  // Link word layout
  localparam int unsigned ADDR_W        = 7;
  localparam int unsigned DATA_W        = 8;
  localparam int unsigned CNT_W         = 3;
  localparam int unsigned WNR_BIT       = 7;
  localparam int unsigned MSB_BIT       = 7;
  localparam logic [2:0]  BIT_CNT_ZERO  = 3'h0;
  localparam logic [2:0]  BIT_CNT_LAST  = 3'h7;
  localparam logic [2:0]  BIT_CNT_ONE   = 3'h1;
  localparam logic [6:0]  ADDR_ONE      = 7'h01;
  localparam logic [6:0]  ADDR_RST      = 7'h00;
  localparam logic [7:0]  BYTE_ZERO     = 8'h00;

  // Address at which data bytes go to or come from the FIFO
  localparam logic [6:0]  FIFO_ADDR     = 7'h00;

  // Write FIFO shape
  localparam int unsigned FIFO_DEPTH    = 16;

  // Bit positions inside the synchroniser vectors
  localparam int unsigned IDX_SCK       = 0;
  localparam int unsigned IDX_NSS       = 1;
  localparam int unsigned IDX_MOSI      = 2;
  localparam int unsigned SYNC_W        = 3;
  // Reset level: frame select idle high, clock and data low
  localparam logic [2:0]  SYNC_RST      = 3'h2;

  // Link timing in the bench, for reference of the sampling margin
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned SCK_PERIOD_NS = 800;
  localparam int unsigned SCK_HALF_CYC  = SCK_PERIOD_NS / (2 * CLK_PERIOD_NS);

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_ADDR,
    ST_DATA
  } srs_state_type;

endpackage

/* File: src/srs_slave.sv */
// Purpose: Serial register access slave, mode 0, with write FIFO
// Assumes: Link pins are asynchronous to clk and far slower than it
// Notes:   Register file and read stream live in the core outside
//
// Notes on behaviour
// R1 - The link runs clock polarity and phase zero, clock idles low, full duplex.
// R2 - Only the slave role exists; clock and frame select are never driven here.
// R3 - A single access is one address byte then one data byte inside one frame.
// R4 - In burst access to a normal address the address steps up after each data byte.
// R5 - When the address is the FIFO address it stays fixed for every data byte.
// R6 - The master holds frame select low between bytes until the last byte ends.
// R7 - The master changes data in on falling clock edges; we sample on rising ones.
// R8 - The data out line changes on falling clock edges only.
// R9 - A transfer starts with frame select falling; clock activity outside is ignored.
// R10 - The data out line is released whenever frame select is high.
// R11 - The first address bit chooses write when one and read when zero.
// R12 - Seven address bits follow, most significant first.
// R13 - Every data byte moves most significant bit first.
// R14 - More data bytes may follow in one frame without a new address.
// R15 - Frame select rising ends the frame; the next byte is an address byte.
// R16 - During a write the old value of the written register is shifted out.
// R17 - Eight rising edges make a byte; frame end drops the count and partial byte.
`timescale 1ns/1ps
module srs_slave (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       ce,
  input  wire logic       sck,
  input  wire logic       frame_select_n,
  input  wire logic       mosi,
  output logic            miso_o,
  output logic            miso_oe,
  output logic [6:0]      reg_addr,
  input  wire logic [7:0] reg_rdata,
  output logic [7:0]      reg_wdata,
  output logic            reg_we,
  output logic            txf_valid,
  input  wire logic       txf_ready,
  output logic [7:0]      txf_data,
  input  wire logic       rxf_valid,
  input  wire logic [7:0] rxf_data,
  output logic            rxf_ready,
  output logic            fifo_overrun
);

  // Three-stage synchronisers and glitch filter
  logic [2:0] sync1_q;
  logic [2:0] sync2_q;
  logic [2:0] sync3_q;
  logic [2:0] filt_q;
  logic [2:0] filt_d;
  logic       sck_rise;
  logic       sck_fall;
  logic       nss_high;
  logic       mosi_f;

  // Protocol state
  srs_pkg::srs_state_type state_q;
  srs_pkg::srs_state_type state_d;
  logic [2:0] bit_cnt_q;
  logic [2:0] bit_cnt_d;
  logic [7:0] rx_sh_q;
  logic [7:0] rx_sh_d;
  logic [7:0] tx_sh_q;
  logic [7:0] tx_sh_d;
  logic       miso_q;
  logic       miso_d;
  logic [6:0] addr_q;
  logic [6:0] addr_d;
  logic       wnr_q;
  logic       wnr_d;
  logic       load_q;
  logic       load_d;
  logic       rx_held_q;
  logic       rx_held_d;
  logic       reg_we_q;
  logic       reg_we_d;
  logic [7:0] wdata_q;
  logic [7:0] wdata_d;
  logic       push_q;
  logic       push_d;
  logic       overrun_q;
  logic       overrun_d;
  logic       fifo_in_ready;
  logic       byte_done;
  logic       fifo_sel;
  logic [7:0] rx_byte;

  // A change is taken once stages two and three agree
  always_comb begin
    for (int i = 0; i < srs_pkg::SYNC_W; i++) begin
      filt_d[i] = (sync2_q[i] == sync3_q[i]) ? sync2_q[i] : filt_q[i];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      sync1_q <= srs_pkg::SYNC_RST;
      sync2_q <= srs_pkg::SYNC_RST;
      sync3_q <= srs_pkg::SYNC_RST;
      filt_q  <= srs_pkg::SYNC_RST;
    end else if (ce) begin
      sync1_q <= {mosi, frame_select_n, sck};                              // R2
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      filt_q  <= filt_d;
    end
  end

  // Edges of the filtered link clock; all gated while frame select is high
  assign nss_high  = filt_d[srs_pkg::IDX_NSS];                             // R9
  assign mosi_f    = filt_d[srs_pkg::IDX_MOSI];
  assign sck_rise  = ce && !nss_high && filt_d[srs_pkg::IDX_SCK] &&
                     !filt_q[srs_pkg::IDX_SCK];                            // R1
  assign sck_fall  = ce && !nss_high && !filt_d[srs_pkg::IDX_SCK] &&
                     filt_q[srs_pkg::IDX_SCK];                             // R1
  assign rx_byte   = {rx_sh_q[6:0], mosi_f};                               // R13
  assign byte_done = sck_rise && (bit_cnt_q == srs_pkg::BIT_CNT_LAST);     // R17
  assign fifo_sel  = (addr_q == srs_pkg::FIFO_ADDR);

  // Pop the read stream as its byte finishes, so the next load sees the new head
  assign rxf_ready = byte_done && (state_q == srs_pkg::ST_DATA) && !wnr_q &&
                     fifo_sel && rx_held_q;                                // R5

  // Next-state logic for the byte engine
  always_comb begin
    state_d   = state_q;
    bit_cnt_d = bit_cnt_q;
    rx_sh_d   = rx_sh_q;
    tx_sh_d   = tx_sh_q;
    miso_d    = miso_q;
    addr_d    = addr_q;
    wnr_d     = wnr_q;
    load_d    = 1'b0;
    rx_held_d = rx_held_q;
    reg_we_d  = 1'b0;
    wdata_d   = wdata_q;
    push_d    = 1'b0;
    overrun_d = 1'b0;
    if (nss_high) begin
      // Frame over: drop partial byte, next byte is an address
      state_d   = srs_pkg::ST_IDLE;                                        // R15
      bit_cnt_d = srs_pkg::BIT_CNT_ZERO;                                   // R17
      tx_sh_d   = srs_pkg::BYTE_ZERO;
      miso_d    = 1'b0;
      rx_held_d = 1'b0;
    end else begin
      if (state_q == srs_pkg::ST_IDLE) begin
        state_d = srs_pkg::ST_ADDR;                                        // R9
      end
      if (sck_rise) begin
        rx_sh_d   = rx_byte;                                               // R7
        bit_cnt_d = bit_cnt_q + srs_pkg::BIT_CNT_ONE;
      end
      if (byte_done) begin
        unique case (state_q)
          srs_pkg::ST_ADDR: begin
            wnr_d   = rx_byte[srs_pkg::WNR_BIT];                           // R11
            addr_d  = rx_byte[6:0];                                        // R12
            state_d = srs_pkg::ST_DATA;                                    // R3
            load_d  = 1'b1;
          end
          srs_pkg::ST_DATA: begin
            if (wnr_q) begin
              wdata_d = rx_byte;
              if (!fifo_sel) begin
                reg_we_d = 1'b1;                                           // R11
              end else if (fifo_in_ready) begin
                push_d = 1'b1;                                             // R5
              end else begin
                overrun_d = 1'b1;
              end
            end
            if (!fifo_sel) begin
              addr_d = addr_q + srs_pkg::ADDR_ONE;                         // R4
            end
            load_d = 1'b1;                                                 // R14
          end
          srs_pkg::ST_IDLE: begin
            state_d = srs_pkg::ST_ADDR;
          end
        endcase
      end
      // Load the reply one cycle after the address settles
      if (load_q) begin
        if (fifo_sel && !wnr_q) begin
          tx_sh_d   = rxf_valid ? rxf_data : srs_pkg::BYTE_ZERO;
          rx_held_d = rxf_valid;
        end else begin
          tx_sh_d = reg_rdata;                                             // R16
        end
      end
      if (sck_fall) begin
        miso_d  = tx_sh_q[srs_pkg::MSB_BIT];                               // R8
        tx_sh_d = {tx_sh_q[6:0], 1'b0};                                    // R13
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_q   <= srs_pkg::ST_IDLE;
      bit_cnt_q <= srs_pkg::BIT_CNT_ZERO;
      rx_sh_q   <= srs_pkg::BYTE_ZERO;
      tx_sh_q   <= srs_pkg::BYTE_ZERO;
      miso_q    <= 1'b0;
      addr_q    <= srs_pkg::ADDR_RST;
      wnr_q     <= 1'b0;
      load_q    <= 1'b0;
      rx_held_q <= 1'b0;
      reg_we_q  <= 1'b0;
      wdata_q   <= srs_pkg::BYTE_ZERO;
      push_q    <= 1'b0;
      overrun_q <= 1'b0;
    end else if (ce) begin
      state_q   <= state_d;
      bit_cnt_q <= bit_cnt_d;
      rx_sh_q   <= rx_sh_d;
      tx_sh_q   <= tx_sh_d;
      miso_q    <= miso_d;
      addr_q    <= addr_d;
      wnr_q     <= wnr_d;
      load_q    <= load_d;
      rx_held_q <= rx_held_d;
      reg_we_q  <= reg_we_d;
      wdata_q   <= wdata_d;
      push_q    <= push_d;
      overrun_q <= overrun_d;
    end
  end

  // Write bytes for the FIFO address; a full FIFO drops the byte and flags it,
  // since the link clock cannot be held back by a slave
  srs_fifo #(
    .WIDTH (srs_pkg::DATA_W),
    .DEPTH (srs_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .rst       (rst),
    .ce        (ce),
    .in_valid  (push_q),
    .in_ready  (fifo_in_ready),
    .in_data   (wdata_q),
    .out_valid (txf_valid),
    .out_ready (txf_ready),
    .out_data  (txf_data)
  );

  // Outputs; the line is only driven inside a frame
  assign miso_o       = miso_q;
  assign miso_oe      = (state_q != srs_pkg::ST_IDLE);                     // R10
  assign reg_addr     = addr_q;
  assign reg_wdata    = wdata_q;
  assign reg_we       = reg_we_q;
  assign fifo_overrun = overrun_q;

  // Checks on the byte engine
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_miso_release: assert property (ce && nss_high |=> !miso_oe)           // R10
    else $error("data out still driven after frame end");
  a_frame_reset: assert property (ce && nss_high |=>                       // R15
      state_q == srs_pkg::ST_IDLE && bit_cnt_q == srs_pkg::BIT_CNT_ZERO)
    else $error("frame end did not reset byte engine");
  a_addr_capture: assert property (byte_done && state_q == srs_pkg::ST_ADDR |=> // R12
      addr_q == $past(rx_byte[6:0]) && wnr_q == $past(rx_byte[7]) &&
      state_q == srs_pkg::ST_DATA)
    else $error("address byte not captured");
  a_addr_step: assert property (byte_done && state_q == srs_pkg::ST_DATA && // R4
      !fifo_sel |=> addr_q == 7'($past(addr_q) + srs_pkg::ADDR_ONE))
    else $error("burst address did not advance");
  a_fifo_hold: assert property (byte_done && state_q == srs_pkg::ST_DATA && // R5
      fifo_sel |=> addr_q == srs_pkg::FIFO_ADDR)
    else $error("FIFO address moved");
  a_write_strobe: assert property (byte_done && state_q == srs_pkg::ST_DATA && // R11
      wnr_q && !fifo_sel |=> reg_we && reg_wdata == $past(rx_byte))
    else $error("write byte not strobed to register");
  a_read_quiet: assert property (byte_done && state_q == srs_pkg::ST_DATA && // R11
      !wnr_q |=> !reg_we && !push_q)
    else $error("read frame caused a write");
  a_prior_value: assert property (ce && load_q && !nss_high && !sck_fall && // R16
      !(fifo_sel && !wnr_q) |=> tx_sh_q == $past(reg_rdata))
    else $error("reply not loaded from register");
  a_miso_edge: assert property ($changed(miso_q) && state_q != srs_pkg::ST_IDLE // R8
      |-> $past(sck_fall))
    else $error("data out changed away from falling edge");
  a_sample_edge: assert property ($changed(rx_sh_q) |-> $past(sck_rise))   // R7
    else $error("data in sampled away from rising edge");
  a_msb_out: assert property (sck_fall |=> miso_q == $past(tx_sh_q[7]))    // R13
    else $error("data out not most significant first");
  a_idle_ignore: assert property (nss_high |=> $stable(rx_sh_q))           // R9
    else $error("link clock taken outside a frame");
  a_bit_count: assert property (sck_rise |=>                               // R17
      bit_cnt_q == 3'($past(bit_cnt_q) + srs_pkg::BIT_CNT_ONE))
    else $error("bit counter did not step on a rising edge");

  // Main scenarios; the overrun cover shows that a full FIFO was reached
  c_fifo_full: cover property (overrun_q);
  c_reg_write: cover property (reg_we && !fifo_sel);
  c_burst_step: cover property (reg_we ##[1:200] reg_we);
  c_fifo_push: cover property (push_q);
  c_fifo_pop: cover property (rxf_ready);

endmodule

/* File: verification/srs_host_model.sv */
// Purpose: Host end of the serial link: drives clock, select and data in
// Assumes: Called from the bench; every change lands on a falling clk edge
// Notes:   Link clock stands low outside frames except for the stray pulses of noise; each level lasts 4 clk
`timescale 1ns/1ps
module srs_host_model (
  input  wire logic clk,
  output logic      sck,
  output logic      frame_select_n,
  output logic      mosi,
  input  wire logic miso_o,
  input  wire logic miso_oe
);
  logic last_q;
  logic miso;

  // A released line shows the inverse of its last value, never a stale copy
  always @(posedge clk) if (miso_oe === 1'b1) last_q <= miso_o;
  assign miso = (miso_oe === 1'b1) ? miso_o : ~last_q;

  initial begin
    sck            = 1'b0;
    frame_select_n = 1'b1;
    mosi           = 1'b0;
    last_q         = 1'b0;
  end

  // Half a link period is four core cycles, 800 ns per bit
  task automatic half();
    repeat (4) @(negedge clk);
  endtask

  task automatic pulse();
    half();
    sck = 1'b1;
    half();
    sck = 1'b0;
  endtask

  task automatic open_frame();
    @(negedge clk);
    frame_select_n = 1'b0;
    half();
  endtask

  // Data in changes with the falling clock, data out is read at the rise
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      mosi = tx[i];
      half();
      rx[i] = miso;
      sck = 1'b1;
      half();
      sck = 1'b0;
    end
  endtask

  // Select stays low across bytes and rises only after the last one
  task automatic close_frame();
    half();
    frame_select_n = 1'b1;
    mosi = ~mosi;
    repeat (8) @(negedge clk);
  endtask

  // Clock pulses with select high, then a frame cut short after nbits
  task automatic noise(input int nbits);
    mosi = 1'b1;
    repeat (3) pulse();
    open_frame();
    repeat (nbits) pulse();
    close_frame();
  endtask
endmodule

/* File: verification/tb_top.sv */
// Purpose: Self-checking bench for the serial register access slave
// Assumes: Bench core holds a 128 byte register file and a read stream
// Notes:   Expected values come from an integer model kept in the bench
`timescale 1ns/1ps
module tb_top;
  logic       clk, rst, ce, sck, frame_select_n, mosi, miso_o, miso_oe;
  logic [6:0] reg_addr;
  logic [7:0] reg_rdata, reg_wdata, txf_data, rxf_data;
  logic       reg_we, txf_valid, txf_ready, rxf_valid, rxf_ready, fifo_overrun;
  logic       drain;
  logic [7:0] regs [0:127];
  logic [7:0] tx_q [$];
  logic [7:0] rx_q [$];
  logic [7:0] stream_q [$];
  int         exp_regs [128];
  int         txf_exp [$];
  int         mismatches, samples_checked, overruns, base, n;

  srs_slave dut (
    .clk(clk), .rst(rst), .ce(ce), .sck(sck), .frame_select_n(frame_select_n),
    .mosi(mosi), .miso_o(miso_o), .miso_oe(miso_oe), .reg_addr(reg_addr),
    .reg_rdata(reg_rdata), .reg_wdata(reg_wdata), .reg_we(reg_we),
    .txf_valid(txf_valid), .txf_ready(txf_ready), .txf_data(txf_data),
    .rxf_valid(rxf_valid), .rxf_data(rxf_data), .rxf_ready(rxf_ready),
    .fifo_overrun(fifo_overrun)
  );

  srs_host_model host (
    .clk(clk), .sck(sck), .frame_select_n(frame_select_n), .mosi(mosi),
    .miso_o(miso_o), .miso_oe(miso_oe)
  );

  always #50 clk = ~clk;

  task automatic chk8(input logic [7:0] got, input int exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: byte %h, expected %0h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: flag %b, expected %b", $time, got, exp);
    end
  endtask

  task automatic end_sim();
    $display("mismatches %0d samples_checked %0d", mismatches, samples_checked);
    if (mismatches == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Core side: the write target is the address before the step that rides with the strobe
  assign reg_rdata = regs[reg_addr];
  always @(posedge clk) begin
    if (reg_we === 1'b1) regs[reg_addr - 7'h01] <= reg_wdata;
    if (fifo_overrun === 1'b1) overruns++;
    if (rxf_ready === 1'b1 && stream_q.size() > 0) void'(stream_q.pop_front());
    if (ce === 1'b1 && txf_valid === 1'b1 && txf_ready === 1'b1)
      chk8(txf_data, txf_exp.size() > 0 ? txf_exp.pop_front() : -1);
  end

  // Stream head, pop stalls and clock-enable gaps while draining change off the sampling edge
  always @(negedge clk) begin
    rxf_valid = stream_q.size() > 0;
    rxf_data  = rxf_valid ? stream_q[0] : 8'hA5;
    txf_ready = drain && ($urandom % 2 == 0);
    ce        = !drain || ($urandom % 4 != 0);
  end

  // One frame: address byte, then every byte of tx_q; replies go to rx_q
  task automatic frame(input logic wr, input logic [6:0] a);
    logic [7:0] r;
    rx_q.delete();
    host.open_frame();
    host.xfer({wr, a}, r);
    foreach (tx_q[k]) begin
      host.xfer(tx_q[k], r);
      rx_q.push_back(r);
    end
    chk1(miso_oe, 1'b1);
    host.close_frame();
    chk1(miso_oe, 1'b0);
  endtask

  task automatic zeros(input int cnt);
    tx_q.delete();
    repeat (cnt) tx_q.push_back(8'h00);
  endtask

  initial begin
    clk = 1'b0;
    rst = 1'b1;
    drain = 1'b0;
    mismatches = 0;
    samples_checked = 0;
    overruns = 0;
    void'($urandom(34101));
    foreach (regs[i]) begin
      regs[i] = 8'($urandom);
      exp_regs[i] = regs[i];
    end
    repeat (4) @(negedge clk);
    rst = 1'b0;
    chk1(miso_oe, 1'b0);
    chk1(reg_we, 1'b0);
    chk1(txf_valid, 1'b0);
    chk8({1'b0, reg_addr}, 0);
    repeat (4) @(negedge clk);
    // Burst write returns old contents, then a longer burst read checks the step
    base = 1 + $urandom % 120;
    tx_q.delete();
    repeat (4) tx_q.push_back(8'($urandom));
    frame(1'b1, 7'(base));
    foreach (tx_q[k]) begin
      chk8(rx_q[k], exp_regs[base + k]);
      exp_regs[base + k] = tx_q[k];
    end
    zeros(5);
    frame(1'b0, 7'(base));
    for (int k = 0; k < 5; k++) chk8(rx_q[k], exp_regs[base + k]);
    // Stray clocks and a cut frame must leave the next address byte intact
    host.noise(5);
    zeros(1);
    frame(1'b0, 7'(base + 2));
    chk8(rx_q[0], exp_regs[base + 2]);
    // FIFO write with the pop side stalled: one byte too many is dropped
    tx_q.delete();
    repeat (17) tx_q.push_back(8'($urandom));
    for (int k = 0; k < 16; k++) txf_exp.push_back(tx_q[k]);
    frame(1'b1, srs_pkg::FIFO_ADDR);
    foreach (rx_q[k]) chk8(rx_q[k], exp_regs[0]);
    chk8(8'(overruns), 1);
    chk8(regs[0], exp_regs[0]);
    chk1(txf_valid, 1'b1);
    // Clock-enable gaps while draining: a frozen FIFO must neither pop nor lose words
    drain = 1'b1;
    for (n = 0; n < 400 && (txf_valid !== 1'b0 || txf_exp.size() > 0); n++) @(negedge clk);
    if (n == 400) begin
      mismatches++;
      $display("mismatch at %0t: FIFO did not drain", $time);
    end
    drain = 1'b0;
    // FIFO read pops the stream at a fixed address, empty reads zero
    stream_q = {8'h3C, 8'($urandom), 8'hC3};
    foreach (stream_q[k]) txf_exp.push_back(stream_q[k]);
    zeros(4);
    frame(1'b0, srs_pkg::FIFO_ADDR);
    for (int k = 0; k < 3; k++) chk8(rx_q[k], txf_exp.pop_front());
    chk8(rx_q[3], 0);
    end_sim();
  end
endmodule
